// ==== hdl/swc_regs.svh ====
/*
  Timing counts and field positions of the sleep and wake-up controller.
  Assumes inclusion by bare name from the design files.
*/
`ifndef SWC_REGS_SVH
`define SWC_REGS_SVH
// ------------------------------------------------------------------
// Timing, interrupt sources and widths
// ------------------------------------------------------------------
`define SWC_OST_TOSC        1024
`define SWC_IRQ_VECTOR      13'h0004
`define SWC_IRQ_SRC_COUNT   3
`define SWC_SRC_EDGE        0
`define SWC_SRC_PORT        1
`define SWC_SRC_CMP         2
`define SWC_WDT_WIDTH       16
`define SWC_WDT_LIMIT       16'hFFFF
`define SWC_PC_WIDTH        13
`endif

// ==== hdl/swc_pkg.sv ====
/*
  Types of the sleep and wake-up controller.
  Includes the header of constants itself, ahead of the package.
*/
`include "swc_regs.svh"
package swc_pkg;
  typedef enum logic [2:0] {
    SWC_RUN   = 3'b000,
    SWC_SLEEP = 3'b001,
    SWC_OST   = 3'b010,
    SWC_FETCH = 3'b011,
    SWC_VECT  = 3'b100
  } swc_state_e;
  typedef enum logic [1:0] {
    SWC_OSC_RC  = 2'b00,
    SWC_OSC_XT  = 2'b01,
    SWC_OSC_HS  = 2'b10,
    SWC_OSC_LP  = 2'b11
  } swc_osc_e;
endpackage

// ==== hdl/swc_edge_detect.sv ====
/*
  Edge interrupt flag capture for the external edge pin.
  Assumes the pin is synchronous to the clock; the flag clear comes from software.
*/
`timescale 1ns/100ps
module swc_edge_detect (
  input  wire logic clock_in,
  input  wire logic nrst_in,
  input  wire logic edge_irq_pin_in,
  input  wire logic edge_select_bit_in,
  input  wire logic flag_clear_in,
  output logic      flag_out
);
  logic prev;
  logic flag;
  logic next_prev;
  logic next_flag;
  logic hit;

  always_comb begin
    next_prev = edge_irq_pin_in;
    hit = edge_select_bit_in ? (edge_irq_pin_in & ~prev) : (~edge_irq_pin_in & prev);
    // Set wins over clear
    next_flag = hit ? 1'b1 : (flag_clear_in ? 1'b0 : flag);
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      prev <= 1'b0;
      flag <= 1'b0;
    end else begin
      prev <= next_prev;
      flag <= next_flag;
    end
  end

  assign flag_out = flag;
endmodule

// ==== hdl/swc_watchdog.sv ====
/*
  Watchdog counter on the always-running clock.
  Assumes the caller asserts clear on sleep entry, wake-up and clear requests.
*/
`timescale 1ns/100ps
`include "swc_regs.svh"
module swc_watchdog #(
  parameter int WIDTH = `SWC_WDT_WIDTH,
  parameter logic [WIDTH-1:0] LIMIT = `SWC_WDT_LIMIT
) (
  input  wire logic clock_in,
  input  wire logic nrst_in,
  input  wire logic enable_in,
  input  wire logic clear_in,
  output logic      timeout_out
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] next_count;
  logic             tout;
  logic             next_tout;

  always_comb begin
    next_count = count;
    next_tout  = 1'b0;
    if (!enable_in || clear_in) begin
      next_count = '0;
    end else if (count == LIMIT) begin
      next_count = '0;
      next_tout  = 1'b1;
    end else begin
      next_count = count + 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      count <= '0;
      tout  <= 1'b0;
    end else begin
      count <= next_count;
      tout  <= next_tout;
    end
  end

  assign timeout_out = tout;
endmodule

// ==== hdl/swc_sleep_wakeup_control.sv ====
/*
  Sleep and wake-up controller: power-down entry, wake sources, start-up wait.
  Assumes clock_in is the always-running watchdog clock, and that the core
  reports the power-down instruction as a one-cycle pulse.
*/
`timescale 1ns/100ps
`include "swc_regs.svh"
module swc_sleep_wakeup_control #(
  parameter int PINS    = 13,
  parameter int OST_CYC = `SWC_OST_TOSC
) (
  input  wire logic            clock_in,
  input  wire logic            nrst_in,
  input  wire logic            sleep_instr_in,
  input  wire logic            clear_wdt_in,
  input  wire logic [12:0]     pc_in,
  input  wire logic            master_clear_pin_in,
  input  wire logic            wdt_enable_in,
  input  wire logic            global_irq_enable_in,
  input  wire logic [1:0]      osc_mode_in,
  input  wire logic            edge_irq_pin_in,
  input  wire logic            edge_select_bit_in,
  input  wire logic            edge_flag_clear_in,
  input  wire logic            edge_irq_enable_in,
  input  wire logic            port_irq_flag_in,
  input  wire logic            port_irq_enable_in,
  input  wire logic            cmp_irq_flag_in,
  input  wire logic            cmp_irq_enable_in,
  input  wire logic [PINS-1:0] pin_data_in,
  input  wire logic [PINS-1:0] pin_oe_in,
  output logic      [PINS-1:0] pin_data_out,
  output logic      [PINS-1:0] pin_oe_out,
  output logic                 osc_drive_out,
  output logic                 core_clk_en_out,
  output logic                 core_reset_out,
  output logic                 prefetch_out,
  output logic      [12:0]     prefetch_addr_out,
  output logic                 vector_out,
  output logic      [12:0]     vector_addr_out,
  output logic                 powerdown_flag_n_out,
  output logic                 timeout_flag_n_out,
  output logic                 edge_flag_out,
  output logic                 master_clear_oe_out,
  output logic                 asleep_out
);
  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  function automatic logic osc_needs_wait(input logic [1:0] mode);
    osc_needs_wait = (mode != swc_pkg::SWC_OSC_RC);
  endfunction

  // Time-out only counts while the watchdog is enabled
  function automatic logic wdt_fired(input logic tout, input logic en);
    wdt_fired = tout & en;
  endfunction

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  swc_pkg::swc_state_e state;
  swc_pkg::swc_state_e next_state;
  logic [10:0]     ost_cnt;
  logic [10:0]     next_ost_cnt;
  logic            pd_n;
  logic            next_pd_n;
  logic            to_n;
  logic            next_to_n;
  logic [PINS-1:0] hold_d;
  logic [PINS-1:0] next_hold_d;
  logic [PINS-1:0] hold_oe;
  logic [PINS-1:0] next_hold_oe;
  logic            osc;
  logic            next_osc;
  logic            rst;
  logic            next_rst;
  logic            pf;
  logic            next_pf;
  logic [12:0]     pf_addr;
  logic [12:0]     next_pf_addr;
  logic            vec;
  logic            next_vec;
  logic            gie_at_wake;
  logic            next_gie_at_wake;
  logic            edge_flag;
  logic            wdt_tout;
  logic            wdt_clear;
  logic            irq_wake;
  logic            master_clear_pin_low;
  logic            entering;
  logic            clk_en;
  logic            next_clk_en;
  logic            asleep;
  logic            next_asleep;
  logic [12:0]     vec_addr;
  logic [12:0]     next_vec_addr;
  logic            master_clear_pin_oe;
  logic            next_master_clear_pin_oe;

  // ------------------------------------------------------------------
  // Sub-blocks
  // ------------------------------------------------------------------
  swc_edge_detect u_edge (
    .clock_in           (clock_in),
    .nrst_in            (nrst_in),
    .edge_irq_pin_in    (edge_irq_pin_in),
    .edge_select_bit_in (edge_select_bit_in),
    .flag_clear_in      (edge_flag_clear_in),
    .flag_out           (edge_flag)
  );

  // Independent clock keeps the counter alive asleep
  swc_watchdog u_wdt (
    .clock_in    (clock_in),
    .nrst_in     (nrst_in),
    .enable_in   (wdt_enable_in),
    .clear_in    (wdt_clear),
    .timeout_out (wdt_tout)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    master_clear_pin_low = ~master_clear_pin_in;
    entering = (state == swc_pkg::SWC_RUN) && sleep_instr_in;
    // Own enable only, no global gate
    irq_wake = (edge_flag & edge_irq_enable_in)
             | (port_irq_flag_in & port_irq_enable_in)
             | (cmp_irq_flag_in & cmp_irq_enable_in);
    next_state       = state;
    next_ost_cnt     = ost_cnt;
    next_pd_n        = pd_n;
    next_to_n        = to_n;
    next_hold_d      = hold_d;
    next_hold_oe     = hold_oe;
    next_osc         = osc;
    next_rst         = 1'b0;
    next_pf          = 1'b0;
    next_pf_addr     = pf_addr;
    next_vec         = 1'b0;
    next_gie_at_wake = gie_at_wake;
    wdt_clear        = clear_wdt_in;
    case (state)
      swc_pkg::SWC_RUN: begin
        next_hold_d  = pin_data_in;
        next_hold_oe = pin_oe_in;
        if (wdt_fired(wdt_tout, wdt_enable_in)) begin
          next_rst  = 1'b1;
          next_to_n = 1'b0;
        end else if (entering) begin
          wdt_clear    = 1'b1;
          next_pd_n    = 1'b0;
          next_to_n    = 1'b1;
          next_osc     = 1'b0;
          next_pf      = 1'b1;
          next_pf_addr = pc_in + 13'h0001;
          next_state   = swc_pkg::SWC_SLEEP;
        end
      end
      swc_pkg::SWC_SLEEP: begin
        // Pending enabled flags fall through here on the first sleep cycle
        if (master_clear_pin_low) begin
          next_rst   = 1'b1;
          next_osc   = 1'b1;
          next_state = swc_pkg::SWC_RUN;
        end else if (wdt_fired(wdt_tout, wdt_enable_in) || irq_wake) begin
          wdt_clear        = 1'b1;
          next_to_n        = ~wdt_fired(wdt_tout, wdt_enable_in);
          next_gie_at_wake = global_irq_enable_in & irq_wake;
          next_osc         = 1'b1;
          next_ost_cnt     = '0;
          next_state       = osc_needs_wait(osc_mode_in) ? swc_pkg::SWC_OST
                                                         : swc_pkg::SWC_FETCH;
        end
      end
      swc_pkg::SWC_OST: begin
        // Oscillator settling before the core sees a clock
        if (ost_cnt == 11'(OST_CYC - 1)) begin
          next_state = swc_pkg::SWC_FETCH;
        end else begin
          next_ost_cnt = ost_cnt + 11'h001;
        end
      end
      swc_pkg::SWC_FETCH: begin
        // Prefetched instruction runs this cycle
        next_state = gie_at_wake ? swc_pkg::SWC_VECT : swc_pkg::SWC_RUN;
      end
      swc_pkg::SWC_VECT: begin
        next_vec   = 1'b1;
        next_state = swc_pkg::SWC_RUN;
      end
      default: begin
        next_state = swc_pkg::SWC_RUN;
      end
    endcase
    if (master_clear_pin_low && state != swc_pkg::SWC_SLEEP) begin
      next_rst   = 1'b1;
      next_osc   = 1'b1;
      next_state = swc_pkg::SWC_RUN;
    end
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state       <= swc_pkg::SWC_RUN;
      ost_cnt     <= '0;
      pd_n        <= 1'b1;
      to_n        <= 1'b1;
      hold_d      <= '0;
      hold_oe     <= '0;
      osc         <= 1'b1;
      rst         <= 1'b0;
      pf          <= 1'b0;
      pf_addr     <= '0;
      vec         <= 1'b0;
      gie_at_wake <= 1'b0;
    end else begin
      state       <= next_state;
      ost_cnt     <= next_ost_cnt;
      pd_n        <= next_pd_n;
      to_n        <= next_to_n;
      hold_d      <= next_hold_d;
      hold_oe     <= next_hold_oe;
      osc         <= next_osc;
      rst         <= next_rst;
      pf          <= next_pf;
      pf_addr     <= next_pf_addr;
      vec         <= next_vec;
      gie_at_wake <= next_gie_at_wake;
    end
  end

  // ------------------------------------------------------------------
  // Output registers
  // ------------------------------------------------------------------
  // Decoded from next values so each output leaves a flip-flop
  // Costs sixteen flops, keeps decode glitches off the core clock gate
  always_comb begin
    next_clk_en   = next_osc && (next_state != swc_pkg::SWC_OST);
    next_asleep   = (next_state == swc_pkg::SWC_SLEEP);
    next_vec_addr = `SWC_IRQ_VECTOR;
    next_master_clear_pin_oe  = 1'b0;
  end

  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clk_en   <= 1'b1;
      asleep   <= 1'b0;
      vec_addr <= `SWC_IRQ_VECTOR;
      master_clear_pin_oe  <= 1'b0;
    end else begin
      clk_en   <= next_clk_en;
      asleep   <= next_asleep;
      vec_addr <= next_vec_addr;
      master_clear_pin_oe  <= next_master_clear_pin_oe;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Pin levels are registered copies, so they lag the core by one cycle
  assign pin_data_out         = hold_d;
  assign pin_oe_out           = hold_oe;
  assign osc_drive_out        = osc;
  assign core_clk_en_out      = clk_en;
  assign core_reset_out       = rst;
  assign prefetch_out         = pf;
  assign prefetch_addr_out    = pf_addr;
  assign vector_out           = vec;
  assign vector_addr_out      = vec_addr;
  assign powerdown_flag_n_out = pd_n;
  assign timeout_flag_n_out   = to_n;
  assign edge_flag_out        = edge_flag;
  assign master_clear_oe_out  = master_clear_pin_oe;
  assign asleep_out           = asleep;
endmodule

// ==== sim/swc_properties.sv ====
/*
  Port checker of the sleep and wake-up controller.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/100ps
module swc_properties #(
  parameter int PINS    = 13,
  parameter int OST_CYC = 1024
) (
  input wire logic            clock_in,
  input wire logic            nrst_in,
  input wire logic            sleep_instr_in,
  input wire logic [12:0]     pc_in,
  input wire logic            master_clear_pin_in,
  input wire logic            global_irq_enable_in,
  input wire logic [1:0]      osc_mode_in,
  input wire logic [PINS-1:0] pin_data_out,
  input wire logic [PINS-1:0] pin_oe_out,
  input wire logic            osc_drive_out,
  input wire logic            core_clk_en_out,
  input wire logic            core_reset_out,
  input wire logic            prefetch_out,
  input wire logic [12:0]     prefetch_addr_out,
  input wire logic            vector_out,
  input wire logic [12:0]     vector_addr_out,
  input wire logic            powerdown_flag_n_out,
  input wire logic            timeout_flag_n_out,
  input wire logic            master_clear_oe_out,
  input wire logic            asleep_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic        go;
  logic [15:0] ost_cnt;
  logic [15:0] next_ost_cnt;
  logic        was_asleep;
  logic        vec_pend;
  logic        next_vec_pend;
  logic [15:0] vec_cnt;
  logic [15:0] next_vec_cnt;
  assign go = sleep_instr_in && !asleep_out && core_clk_en_out && master_clear_pin_in;
  // Wait spans the start-up delay, too long for a delay range
  always_comb begin
    next_vec_pend = vec_pend;
    next_vec_cnt  = vec_pend ? vec_cnt + 16'h0001 : 16'h0000;
    if (vector_out || !master_clear_pin_in) begin
      next_vec_pend = 1'b0;
    end else if (was_asleep && !asleep_out && global_irq_enable_in && timeout_flag_n_out) begin
      next_vec_pend = 1'b1;
      next_vec_cnt  = 16'h0001;
    end
  end
  always_comb begin
    next_ost_cnt = (osc_drive_out && !core_clk_en_out) ? ost_cnt + 16'h0001 : 16'h0000;
  end
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ost_cnt    <= 16'h0000;
      was_asleep <= 1'b0;
      vec_pend   <= 1'b0;
      vec_cnt    <= 16'h0000;
    end else begin
      ost_cnt    <= next_ost_cnt;
      was_asleep <= asleep_out;
      vec_pend   <= next_vec_pend;
      vec_cnt    <= next_vec_cnt;
    end
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_enter_sleep: assert property (
    go |=> asleep_out && !osc_drive_out && !core_clk_en_out) else $error("sleep entry wrong");
  chk_flag_update: assert property (
    go |=> !powerdown_flag_n_out && timeout_flag_n_out) else $error("entry flags wrong");
  chk_prefetch_next: assert property (
    go |=> prefetch_out && prefetch_addr_out == $past(pc_in) + 13'h0001)
    else $error("prefetch wrong");
  chk_pins_held: assert property (
    asleep_out && $past(asleep_out) |-> $stable(pin_data_out) && $stable(pin_oe_out))
    else $error("pins moved asleep");
  chk_pin_free: assert property (
    master_clear_oe_out == 1'b0) else $error("master clear driven");
  chk_vector_addr: assert property (
    vector_out |-> vector_addr_out == 13'h0004) else $error("vector address wrong");
  chk_inline_resume: assert property (
    $fell(asleep_out) && !global_irq_enable_in |-> !vector_out [*8]) else $error("vector taken");
  chk_vector_taken: assert property (
    vec_pend |-> vec_cnt <= OST_CYC + 3) else $error("vector missing");
  chk_ost_length: assert property (
    $rose(core_clk_en_out) && osc_mode_in != 2'b00 && master_clear_pin_in
    |-> ost_cnt == OST_CYC) else $error("start-up wait length wrong");
  chk_wdt_no_reset: assert property (
    $past(asleep_out) && $fell(timeout_flag_n_out) |-> !core_reset_out [*4])
    else $error("reset on sleep time-out");
  chk_master_clear_pin_reset: assert property (
    !master_clear_pin_in && asleep_out |-> ##[1:3] core_reset_out) else $error("no reset");
  cov_sleep: cover property (go);
  cov_vector: cover property (vector_out);
  cov_wdt_wake: cover property ($past(asleep_out) && $fell(timeout_flag_n_out));
endmodule

// ==== sim/swc_core_model.sv ====
/*
  Core-side model: issues the power-down instruction and drives pins.
  Assumes the bench requests sleep with go_in for one cycle.
*/
`timescale 1ns/100ps
module swc_core_model (
  input  wire logic        clock_in,
  input  wire logic        nrst_in,
  input  wire logic        go_in,
  input  wire logic        clk_en_in,
  output logic             sleep_instr_out,
  output logic [12:0]      pc_out,
  output logic [12:0]      pin_data_out,
  output logic [12:0]      pin_oe_out
);
  logic [12:0] cnt;
  logic [12:0] next_cnt;
  logic        next_sleep;
  always_comb begin
    next_cnt   = cnt + 13'h0001;
    next_sleep = go_in && clk_en_in;
  end
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cnt             <= 13'h1FF0;
      sleep_instr_out <= 1'b0;
    end else begin
      cnt             <= next_cnt;
      sleep_instr_out <= next_sleep;
    end
  end
  // Kept moving so a missed freeze shows
  assign pc_out       = cnt;
  assign pin_data_out = cnt;
  assign pin_oe_out   = ~cnt;
endmodule

// ==== sim/swc_sleep_wakeup_control_tb.sv ====
/*
  Testbench of the sleep and wake-up controller.
  Assumes the core model and the port checker are compiled alongside.
*/
`timescale 1ns/100ps
module swc_sleep_wakeup_control_tb;
  logic        clock_in, nrst_in, go, sleep_instr, master_clear_pin, wdt_en, global_irq_enable, clr_wdt;
  logic        e_pin, e_sel, e_clr, e_en, p_flag, p_en, c_flag, c_en;
  logic [1:0]  osc_mode;
  logic [12:0] pc, pdi, poi, pdo, poe, pf_addr, v_addr;
  logic        osc, clk_en, c_rst, pf, vec, pd_n, to_n, e_flag, m_oe, asleep;
  int          fails, check_count, rst_seen, vec_seen;
  swc_sleep_wakeup_control #(.PINS(13), .OST_CYC(4)) i_dut (
    .clock_in(clock_in), .nrst_in(nrst_in), .sleep_instr_in(sleep_instr),
    .clear_wdt_in(clr_wdt), .pc_in(pc), .master_clear_pin_in(master_clear_pin), .wdt_enable_in(wdt_en),
    .global_irq_enable_in(global_irq_enable), .osc_mode_in(osc_mode), .edge_irq_pin_in(e_pin),
    .edge_select_bit_in(e_sel), .edge_flag_clear_in(e_clr), .edge_irq_enable_in(e_en),
    .port_irq_flag_in(p_flag), .port_irq_enable_in(p_en), .cmp_irq_flag_in(c_flag),
    .cmp_irq_enable_in(c_en), .pin_data_in(pdi), .pin_oe_in(poi), .pin_data_out(pdo),
    .pin_oe_out(poe), .osc_drive_out(osc), .core_clk_en_out(clk_en), .core_reset_out(c_rst),
    .prefetch_out(pf), .prefetch_addr_out(pf_addr), .vector_out(vec),
    .vector_addr_out(v_addr), .powerdown_flag_n_out(pd_n), .timeout_flag_n_out(to_n),
    .edge_flag_out(e_flag), .master_clear_oe_out(m_oe), .asleep_out(asleep));
  swc_core_model i_core (.clock_in(clock_in), .nrst_in(nrst_in), .go_in(go),
    .clk_en_in(clk_en), .sleep_instr_out(sleep_instr), .pc_out(pc),
    .pin_data_out(pdi), .pin_oe_out(poi));
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  always @(posedge clock_in) begin
    if (vec === 1'b1) vec_seen++;
    if (c_rst === 1'b1) rst_seen++;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock_in);
    #10;
  endtask
  // Bounded wait for the sleep state to reach a level
  task automatic wait_on(input logic want, input int lim);
    for (int i = 0; i < lim && asleep !== want; i++) cyc(1);
    if (asleep !== want) begin
      fails++;
      $display("MISMATCH asleep expected %b seen %b", want, asleep);
      print_verdict();
    end
  endtask
  task automatic enter_sleep;
    go = 1'b1;
    cyc(1);
    go = 1'b0;
    wait_on(1'b1, 5);
    chk("powerdown_flag_n", 1'b0, pd_n);
    chk("timeout_flag_n", 1'b1, to_n);
    chk("core_clk_en", 1'b0, clk_en);
  endtask
  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    {nrst_in, go, wdt_en, global_irq_enable, clr_wdt, e_pin, e_sel, e_clr, e_en} = '0;
    {p_flag, p_en, c_flag, c_en} = '0;
    master_clear_pin = 1'b1;
    osc_mode = 2'b01;
    repeat (8) @(posedge clock_in);
    #10 nrst_in = 1'b1;
    cyc(1);
    chk("powerdown_flag_n", 1'b1, pd_n);
    chk("master_clear_oe", 1'b0, m_oe);
    $display("test reset done");
    enter_sleep();
    cyc(3);
    {e_sel, e_en, global_irq_enable, e_pin} = 4'hF;
    vec_seen = 0;
    wait_on(1'b0, 20);
    cyc(2);
    chk("core_clk_en ost", 1'b0, clk_en);
    cyc(12);
    chk("vector", 1'b1, vec_seen != 0);
    chk("timeout_flag_n", 1'b1, to_n);
    {e_clr, e_pin} = 2'b10;
    cyc(1);
    e_clr = 1'b0;
    cyc(2);
    chk("edge_flag clear", 1'b0, e_flag);
    $display("test edge wake done");
    {global_irq_enable, p_flag} = 2'b01;
    enter_sleep();
    cyc(20);
    chk("asleep disabled", 1'b1, asleep);
    osc_mode = 2'b00;
    vec_seen = 0;
    p_en = 1'b1;
    wait_on(1'b0, 10);
    cyc(2);
    chk("core_clk_en rc", 1'b1, clk_en);
    cyc(12);
    chk("vector", 1'b0, vec_seen != 0);
    {p_flag, p_en, c_flag, c_en} = 4'h3;
    $display("test port wake done");
    enter_sleep();
    wait_on(1'b0, 4);
    {c_flag, c_en, e_pin} = 3'b001;
    $display("test pending wake done");
    cyc(2);
    chk("edge_flag rising", 1'b1, e_flag);
    {e_clr, e_sel} = 2'b10;
    cyc(1);
    e_clr = 1'b0;
    enter_sleep();
    e_pin = 1'b0;
    wait_on(1'b0, 20);
    chk("edge_flag falling", 1'b1, e_flag);
    {e_clr, e_en} = 2'b10;
    cyc(1);
    {e_clr, wdt_en} = 2'b01;
    rst_seen = 0;
    $display("test falling edge done");
    enter_sleep();
    wait_on(1'b0, 70000);
    cyc(2);
    chk("timeout_flag_n", 1'b0, to_n);
    chk("core_reset", 1'b0, rst_seen != 0);
    wdt_en = 1'b0;
    $display("test watchdog wake done");
    enter_sleep();
    master_clear_pin = 1'b0;
    cyc(3);
    master_clear_pin = 1'b1;
    chk("core_reset", 1'b1, rst_seen != 0);
    wait_on(1'b0, 5);
    $display("test master clear done");
    print_verdict();
  end
endmodule
bind swc_sleep_wakeup_control swc_properties #(.PINS(PINS), .OST_CYC(OST_CYC)) i_props (
  .clock_in, .nrst_in, .sleep_instr_in, .pc_in, .master_clear_pin_in, .global_irq_enable_in,
  .osc_mode_in, .pin_data_out, .pin_oe_out, .osc_drive_out, .core_clk_en_out, .core_reset_out,
  .prefetch_out, .prefetch_addr_out, .vector_out, .vector_addr_out, .powerdown_flag_n_out,
  .timeout_flag_n_out, .master_clear_oe_out, .asleep_out);
